// File: pkg/kbil_pkg.sv
// Package of constants and types for the keypad interrupt latch
`default_nettype none
package kbil_pkg;
  localparam int unsigned NUM_KEYS = 5;
  // Register map (byte offsets on the plain register port)
  localparam logic [3:0] ADDR_STATUS_CTRL = 4'h0;
  localparam logic [3:0] ADDR_ENABLE      = 4'h1;
  localparam logic [3:0] ADDR_BREAK_CTRL  = 4'h2;
  // Status and control register fields
  localparam int unsigned BIT_LEVEL_SENSE = 0;
  localparam int unsigned BIT_MASK        = 1;
  localparam int unsigned BIT_ACK         = 2;
  localparam int unsigned BIT_PENDING     = 3;
  // Break control register field
  localparam int unsigned BIT_BREAK_CLEAR = 0;
  // Reset values
  localparam logic [4:0] RST_ENABLE = 5'h00;
  localparam logic [7:0] RST_DATA   = 8'h00;
  // Vector address presented with the request
  localparam logic [15:0] VECTOR_ADDR = 16'hFFDE;
  // Control bits written by software
  typedef struct packed {
    logic level_sense_select;
    logic request_mask_bit;
    logic break_clear_enable;
  } kbil_ctrl_type;
endpackage : kbil_pkg
`default_nettype wire

// File: design/kbil_sync.sv
// Two-flop synchroniser for the keypad inputs
`default_nettype none
module kbil_sync #(
  parameter int unsigned WIDTH = 5
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  // First stage read only by second stage; idle level is high
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q   <= '1;
      sync_out <= '1;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // kbil_sync
`default_nettype wire

// File: design/kbil_latch.sv
// Keypad interrupt latch: pins, request latch and register port
// Functional notes
// - Five inputs, per-input enable, one mask
// - Enable bit also switches pullup on
// - Latch request on low after all high
// - Edge mode ignores edge while another low
// - Level mode holds request while any low
// - Level mode clears after ack and all high
// - Ack from vector fetch or software write
// - Edge after ack write latches new request
// - Unmasked request presented, vector FFDE
// - Edge mode ack clears request at once
// - Reset clears request and level select
// - Pending flag readable, independent of mask
// - Enable forces pin input, direction ignored
// - Active in wait/stop; request wakes CPU
// - Break with clear disabled blocks ack write
// - Break with clear enabled allows clearing
// - Ack bit write-only, reads zero
// - Level select one adds low-level sense
// - Reset clears mask and all enables
//
// Our own choices: the address-and-strobe port and the register offsets.
`default_nettype none
module kbil_latch #(
  parameter int unsigned NUM_KEYS = kbil_pkg::NUM_KEYS
) (
  input  wire logic                clk,
  input  wire logic                rstn,
  // Register port
  input  wire logic [3:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output var  logic [7:0]          reg_rdata,
  // Keypad pins and port logic
  input  wire logic [NUM_KEYS-1:0] keypad_irq_pin,
  input  wire logic [NUM_KEYS-1:0] port_dir_out,
  output logic      [NUM_KEYS-1:0] pullup_en,
  output logic      [NUM_KEYS-1:0] pin_out_en,
  // CPU side
  input  wire logic                vector_fetch,
  input  wire logic                break_state,
  output logic                     irq_request,
  output logic                     wake_request,
  output logic      [15:0]         irq_vector
);
  logic [NUM_KEYS-1:0] input_enable_bits_q;
  logic                level_sense_select_q;
  logic                request_mask_bit_q;
  logic                break_clear_enable_q;
  logic                pending_flag_q;
  logic                pending_flag_d;
  logic                ack_seen_q;
  logic                ack_seen_d;
  logic                any_low_q;
  logic [NUM_KEYS-1:0] keys_sync;
  logic [7:0]          rdata_d;
  kbil_pkg::kbil_ctrl_type ctrl;

  // Synchronise the pins before detection
  kbil_sync #(
    .WIDTH    (NUM_KEYS)
  ) u_sync (
    .clk      (clk),
    .rstn     (rstn),
    .async_in (keypad_irq_pin),
    .sync_out (keys_sync)
  );

  // Write decodes
  wire wr_status = reg_wr && (reg_addr == kbil_pkg::ADDR_STATUS_CTRL);
  wire wr_enable = reg_wr && (reg_addr == kbil_pkg::ADDR_ENABLE);
  wire wr_break  = reg_wr && (reg_addr == kbil_pkg::ADDR_BREAK_CTRL);
  wire ack_write = wr_status && reg_wdata[kbil_pkg::BIT_ACK];

  // Acknowledge; software write gated while break protects the flag
  wire ack_blocked = break_state && !break_clear_enable_q;
  wire ack_event   = vector_fetch || (ack_write && !ack_blocked);

  // Enabled-input level detection
  wire any_low   = |(input_enable_bits_q & ~keys_sync);
  wire edge_trig = any_low && !any_low_q;

  // Pullups and pin direction follow enables
  assign pullup_en  = input_enable_bits_q;
  assign pin_out_en = port_dir_out & ~input_enable_bits_q;

  assign ctrl.level_sense_select = level_sense_select_q;
  assign ctrl.request_mask_bit   = request_mask_bit_q;
  assign ctrl.break_clear_enable = break_clear_enable_q;

  // Request presentation
  assign irq_request  = pending_flag_q && !ctrl.request_mask_bit;
  assign wake_request = irq_request;
  assign irq_vector   = kbil_pkg::VECTOR_ADDR;

  // Next pending state: set wins over clear
  always_comb begin
    pending_flag_d = pending_flag_q;
    ack_seen_d     = ack_seen_q;
    if (ctrl.level_sense_select) begin
      if (ack_event) begin
        ack_seen_d = 1'b1;
      end
      if ((ack_event || ack_seen_q) && !any_low) begin
        pending_flag_d = 1'b0;
        ack_seen_d     = 1'b0;
      end
      if (any_low && !(ack_event || ack_seen_q)) begin
        pending_flag_d = 1'b1;
      end
    end else begin
      ack_seen_d = 1'b0;
      if (ack_event) begin
        pending_flag_d = 1'b0;
      end
    end
    if (edge_trig) begin
      pending_flag_d = 1'b1;
      ack_seen_d     = 1'b0;
    end
  end

  // Pending flag, ack memory and previous level
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pending_flag_q <= 1'b0;
      ack_seen_q     <= 1'b0;
      any_low_q      <= 1'b0;
    end else begin
      pending_flag_q <= pending_flag_d;
      ack_seen_q     <= ack_seen_d;
      any_low_q      <= any_low;
    end
  end

  // Control registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      input_enable_bits_q  <= NUM_KEYS'(kbil_pkg::RST_ENABLE);
      level_sense_select_q <= 1'b0;
      request_mask_bit_q   <= 1'b0;
      break_clear_enable_q <= 1'b0;
    end else begin
      if (wr_enable) begin
        input_enable_bits_q <= reg_wdata[NUM_KEYS-1:0];
      end
      if (wr_status) begin
        level_sense_select_q <= reg_wdata[kbil_pkg::BIT_LEVEL_SENSE];
        request_mask_bit_q   <= reg_wdata[kbil_pkg::BIT_MASK];
      end
      if (wr_break) begin
        break_clear_enable_q <= reg_wdata[kbil_pkg::BIT_BREAK_CLEAR];
      end
    end
  end

  // Read mux; ack bit always reads zero
  always_comb begin
    rdata_d = kbil_pkg::RST_DATA;
    case (reg_addr)
      kbil_pkg::ADDR_STATUS_CTRL: begin
        rdata_d[kbil_pkg::BIT_LEVEL_SENSE] = level_sense_select_q;
        rdata_d[kbil_pkg::BIT_MASK]        = request_mask_bit_q;
        rdata_d[kbil_pkg::BIT_PENDING]     = pending_flag_q;
      end
      kbil_pkg::ADDR_ENABLE: begin
        rdata_d[NUM_KEYS-1:0] = input_enable_bits_q;
      end
      kbil_pkg::ADDR_BREAK_CTRL: begin
        rdata_d[kbil_pkg::BIT_BREAK_CLEAR] = break_clear_enable_q;
      end
      default: begin
        rdata_d = kbil_pkg::RST_DATA;
      end
    endcase
  end

  // Read data valid the cycle after the strobe only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= kbil_pkg::RST_DATA;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= kbil_pkg::RST_DATA;
    end
  end

  // Assertions
  property p_edge_latch;
    @(posedge clk) disable iff (!rstn)
      edge_trig |=> pending_flag_q;
  endproperty
  a_edge_latch: assert property (p_edge_latch)
    else $error("edge did not latch request");

  property p_edge_ack_clear;
    @(posedge clk) disable iff (!rstn)
      (!level_sense_select_q && ack_event && !edge_trig)
        |=> !pending_flag_q;
  endproperty
  a_edge_ack_clear: assert property (p_edge_ack_clear)
    else $error("edge-mode ack did not clear");

  property p_level_hold;
    @(posedge clk) disable iff (!rstn)
      (level_sense_select_q && pending_flag_q && any_low)
        |=> pending_flag_q;
  endproperty
  a_level_hold: assert property (p_level_hold)
    else $error("request dropped while key low");

  property p_break_protect;
    @(posedge clk) disable iff (!rstn)
      (ack_write && ack_blocked && !vector_fetch && pending_flag_q)
        |=> pending_flag_q;
  endproperty
  a_break_protect: assert property (p_break_protect)
    else $error("ack cleared flag in protected break");

  property p_mask;
    @(posedge clk) disable iff (!rstn)
      irq_request == (pending_flag_q && !request_mask_bit_q);
  endproperty
  a_mask: assert property (p_mask)
    else $error("irq not gated by mask");

  property p_read_pending;
    @(posedge clk) disable iff (!rstn)
      (reg_rd && reg_addr == kbil_pkg::ADDR_STATUS_CTRL)
        |=> reg_rdata[kbil_pkg::BIT_PENDING] == $past(pending_flag_q);
  endproperty
  a_read_pending: assert property (p_read_pending)
    else $error("pending flag misread");

  property p_ack_reads_zero;
    @(posedge clk) disable iff (!rstn)
      !reg_rdata[kbil_pkg::BIT_ACK];
  endproperty
  a_ack_reads_zero: assert property (p_ack_reads_zero)
    else $error("ack bit read as one");

  property p_pullup;
    @(posedge clk) disable iff (!rstn)
      $rose(input_enable_bits_q[0]) |-> pullup_en[0] && !pin_out_en[0];
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("enable did not set pullup and input");

  property p_sync_delay;
    @(posedge clk) disable iff (!rstn)
      ($past(rstn) && $past(rstn, 2))
        |-> keys_sync == $past(keypad_irq_pin, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("synchroniser delay wrong");

  // No level-mode clear without an acknowledge
  property p_level_no_clear;
    @(posedge clk) disable iff (!rstn)
      (level_sense_select_q && pending_flag_q && !ack_event && !ack_seen_q)
        |=> pending_flag_q;
  endproperty
  a_level_no_clear: assert property (p_level_no_clear)
    else $error("level request cleared without ack");

  // Remembered ack clears once all keys high
  property p_level_late_clear;
    @(posedge clk) disable iff (!rstn)
      (level_sense_select_q && ack_seen_q && !any_low)
        |=> !pending_flag_q;
  endproperty
  a_level_late_clear: assert property (p_level_late_clear)
    else $error("level request kept after ack and release");

  // Enabled pins are never driven
  property p_pin_input;
    @(posedge clk) disable iff (!rstn)
      (pin_out_en & input_enable_bits_q) == '0;
  endproperty
  a_pin_input: assert property (p_pin_input)
    else $error("enabled pin driven as output");

  // Unmasked request wakes the CPU
  property p_wake;
    @(posedge clk) disable iff (!rstn)
      irq_request |-> wake_request;
  endproperty
  a_wake: assert property (p_wake)
    else $error("request did not raise wake");

  // First cycle after reset shows the reset state
  property p_reset_clear;
    @(posedge clk) disable iff (!rstn)
      !$past(rstn)
        |-> !pending_flag_q && !level_sense_select_q && !request_mask_bit_q
          && (input_enable_bits_q == '0);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("state not cleared by reset");

  c_edge: cover property (@(posedge clk) disable iff (!rstn)
    edge_trig ##1 irq_request);
  c_level_clear: cover property (@(posedge clk) disable iff (!rstn)
    level_sense_select_q && ack_event && any_low ##[1:20] !pending_flag_q);
  c_break: cover property (@(posedge clk) disable iff (!rstn)
    ack_write && ack_blocked && pending_flag_q);
  c_break_clear: cover property (@(posedge clk) disable iff (!rstn)
    ack_write && break_state && break_clear_enable_q && pending_flag_q);
  c_level_hold: cover property (@(posedge clk) disable iff (!rstn)
    level_sense_select_q && ack_seen_q && any_low);
endmodule // kbil_latch
`default_nettype wire

// File: bench/kbil_keys_model.sv
// Keypad partner model: pressed keys pull pins low
`default_nettype none
module kbil_keys_model (
  input  wire logic       clk,
  input  wire logic [4:0] press,
  input  wire logic [4:0] pullup_en,
  output var  logic [4:0] pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] last_q = 5'h00;
  // Pressed low, pulled up high, floating pins wander
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (press[i]) pin[i] = 1'b0;
      else if (pullup_en[i]) pin[i] = 1'b1;
      else pin[i] = ~last_q[i];
    end
  end
  // Last level, for the wandering pattern
  always_ff @(posedge clk) last_q <= pin;
endmodule // kbil_keys_model
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench for the keypad interrupt latch
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] ACK = 8'h01 << kbil_pkg::BIT_ACK;
  localparam logic [7:0] MSK = 8'h01 << kbil_pkg::BIT_MASK;
  localparam logic [7:0] LVL = 8'h01 << kbil_pkg::BIT_LEVEL_SENSE;
  logic clk, rstn, reg_wr, reg_rd, vector_fetch, break_state;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic [4:0] pin, dir, press, pullup_en, pin_out_en;
  logic irq_request, wake_request;
  logic [15:0] irq_vector;
  int error_cnt, n_compared, seed, k;
  kbil_latch dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .keypad_irq_pin(pin), .port_dir_out(dir),
    .pullup_en(pullup_en), .pin_out_en(pin_out_en),
    .vector_fetch(vector_fetch), .break_state(break_state),
    .irq_request(irq_request), .wake_request(wake_request),
    .irq_vector(irq_vector));
  kbil_keys_model keys (.clk(clk), .press(press),
    .pullup_en(pullup_en), .pin(pin));
  // Clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Expected status byte
  function automatic logic [7:0] stat(logic p, logic m, logic l);
    return {4'h0, p, 1'b0, m, l};
  endfunction
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    v = reg_rdata;
  endtask
  task automatic fetch();
    @(posedge clk);
    vector_fetch <= 1'b1;
    @(posedge clk);
    vector_fetch <= 1'b0;
  endtask
  task automatic stat_is(string nm, logic [7:0] e);
    rd(kbil_pkg::ADDR_STATUS_CTRL, d);
    chk(nm, {8'h00, e}, {8'h00, d});
  endtask
  // Watchdog
  initial begin
    cyc(20000);
    error_cnt++;
    give_verdict();
  end
  initial begin
    {rstn, reg_wr, reg_rd, vector_fetch, break_state} = 5'h00;
    {reg_addr, reg_wdata, dir, press} = 22'h000000;
    error_cnt = 0;
    n_compared = 0;
    seed = 43;
    cyc(12);
    rstn <= 1'b1;
    stat_is("status", stat(0, 0, 0));
    rd(kbil_pkg::ADDR_ENABLE, d);
    chk("enable", 16'h0000, {8'h00, d});
    rd(4'hF, d);
    chk("unmapped", 16'h0000, {8'h00, d});
    // Start-up: mask, enable, let pullups settle, ack, unmask
    wr(kbil_pkg::ADDR_STATUS_CTRL, MSK);
    wr(kbil_pkg::ADDR_ENABLE, 8'h1F);
    dir <= 5'($random(seed));
    cyc(3);
    wr(kbil_pkg::ADDR_STATUS_CTRL, MSK | ACK);
    stat_is("init", stat(0, 1, 0));
    chk("irqinit", 16'h0000, {14'h0, irq_request, wake_request});
    wr(kbil_pkg::ADDR_STATUS_CTRL, 8'h00);
    chk("pullup", 16'h001F, {11'h000, pullup_en});
    chk("oe", {11'h000, dir & ~5'h1F}, {11'h000, pin_out_en});
    // Each key alone in edge mode
    for (k = 0; k < 5; k++) begin
      press <= 5'h01 << k;
      cyc(5);
      stat_is("pend", stat(1, 0, 0));
      chk("irq", 16'h0003, {14'h0, irq_request, wake_request});
      chk("vector", kbil_pkg::VECTOR_ADDR, irq_vector);
      wr(kbil_pkg::ADDR_STATUS_CTRL, ACK);
      stat_is("ackclr", stat(0, 0, 0));
      press <= 5'h00;
      cyc(5);
    end
    // Random key patterns from all high, edge mode
    repeat (6) begin
      press <= 5'($random(seed));
      cyc(5);
      stat_is("rndpend", stat(press != 5'h00, 0, 0));
      wr(kbil_pkg::ADDR_STATUS_CTRL, ACK);
      stat_is("rndack", stat(0, 0, 0));
      press <= 5'h00;
      cyc(5);
    end
    // Edge while another key low is ignored
    k = {$random(seed)} % 4;
    press <= 5'h01 << k;
    cyc(5);
    wr(kbil_pkg::ADDR_STATUS_CTRL, ACK);
    press <= 5'h03 << k;
    cyc(5);
    stat_is("noedge", stat(0, 0, 0));
    press <= 5'h00;
    cyc(5);
    press <= 5'h10;
    cyc(5);
    stat_is("newedge", stat(1, 0, 0));
    // Masked request still pending, vector fetch clears
    wr(kbil_pkg::ADDR_STATUS_CTRL, MSK);
    stat_is("masked", stat(1, 1, 0));
    chk("irqmask", 16'h0000, {14'h0, irq_request, wake_request});
    fetch();
    stat_is("fetchclr", stat(0, 1, 0));
    press <= 5'h00;
    // Level mode: ack first, then release
    wr(kbil_pkg::ADDR_STATUS_CTRL, LVL);
    press <= 5'h04;
    cyc(5);
    fetch();
    cyc(2);
    stat_is("lvlhold", stat(1, 0, 1));
    press <= 5'h00;
    cyc(5);
    stat_is("lvlclr", stat(0, 0, 1));
    // Level mode: release first, then ack
    press <= 5'h02;
    cyc(5);
    press <= 5'h00;
    cyc(5);
    stat_is("lvlwait", stat(1, 0, 1));
    wr(kbil_pkg::ADDR_STATUS_CTRL, ACK | LVL);
    stat_is("lvlack", stat(0, 0, 1));
    // Break state protects then allows clearing
    wr(kbil_pkg::ADDR_STATUS_CTRL, 8'h00);
    press <= 5'h01;
    cyc(5);
    press <= 5'h00;
    break_state <= 1'b1;
    wr(kbil_pkg::ADDR_STATUS_CTRL, ACK);
    stat_is("brkkeep", stat(1, 0, 0));
    wr(kbil_pkg::ADDR_BREAK_CTRL, 8'h01);
    wr(kbil_pkg::ADDR_STATUS_CTRL, ACK);
    break_state <= 1'b0;
    cyc(3);
    stat_is("brkclr", stat(0, 0, 0));
    // Reset with a key held low in level mode
    wr(kbil_pkg::ADDR_STATUS_CTRL, LVL);
    press <= 5'h08;
    cyc(5);
    rstn <= 1'b0;
    cyc(2);
    rstn <= 1'b1;
    cyc(5);
    stat_is("rstclr", stat(0, 0, 0));
    rd(kbil_pkg::ADDR_ENABLE, d);
    chk("rstenable", 16'h0000, {8'h00, d});
    chk("rstpull", 16'h0000, {11'h000, pullup_en});
    chk("rstoe", {11'h000, dir}, {11'h000, pin_out_en});
    give_verdict();
  end
endmodule // tb
`default_nettype wire
